/* File: design/boot_strap_consts.svh */
// Constants for the boot strap configuration reader.
// Assumes a 20 MHz core clock; times in nanoseconds.
`ifndef BOOT_STRAP_CONSTS_SVH
`define BOOT_STRAP_CONSTS_SVH
`define CLK_PERIOD_NS 50
`define DECAY_TIME_NS 2000
`define HOLD_TIME_NS 10000
// Least wait rounds up, longest hold rounds down
`define DECAY_CYCLES ((`DECAY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYCLES (`HOLD_TIME_NS / `CLK_PERIOD_NS)
// Sample midway inside the valid window
`define SAMPLE_CYCLES ((`DECAY_CYCLES + `HOLD_CYCLES) / 2)
`define STRAP_LSB 2
`define STRAP_WIDTH 8
`define PRECHARGE_VALUE 8'hFF
`define PRECHARGE_CYCLES 4
`define MEM_SIZE_LSB 2
`define MEM_SIZE_128M 2'h3
`define MEM_SIZE_64M 2'h2
`define MEM_SIZE_256M 2'h1
`define MEM_SIZE_RSVD 2'h0
`endif

/* File: design/boot_strap_pkg.sv */
// Types for the boot strap configuration reader.
// Assumes boot_strap_consts.svh supplies the numbers.
package boot_strap_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRECHARGE = 5'h02,
      ST_RELEASE = 5'h04,
      ST_WAIT = 5'h08,
      ST_DONE = 5'h10
   } seq_state_e;
   typedef enum logic [1:0] {
      MEM_RSVD = 2'h0,
      MEM_256M = 2'h1,
      MEM_64M = 2'h2,
      MEM_128M = 2'h3
   } mem_size_e;
endpackage : boot_strap_pkg

/* File: design/boot_strap_config_reader.sv */
// Boot strap configuration reader: precharge, release, timed capture of strap pins,
// then hand the pins over to the upper display data bits.
// Assumes pins 9:2 carry weak pull-downs on zero straps and an external pad resolves drive.
// Behaviour
// RQ1: After reset all pins are inputs.
// RQ2: Drive outputs, write ones, release, read.
// RQ3: Sequence runs first, before display handover.
// RQ4: Pulled-down pin reads zero, others one.
// RQ5: Wait at least decay time before sampling.
// RQ6: Sample before unstrapped pins lose charge.
// RQ7: Captured byte held for later readers.
// RQ8: Afterwards pins carry upper display data.
// RQ9: Byte exists only as sampled pin levels.
// RQ10: Set writes drive only one bits high.
// RQ11: Bits 3:2 encode memory device size.
// RQ12: Count cycles, sample strictly inside window.
`timescale 1ns/1ps
`include "boot_strap_consts.svh"
module boot_strap_config_reader #(
   parameter int WIDTH = `STRAP_WIDTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] strap_pin_in,
   output logic [WIDTH-1:0] strap_pin_out,
   output logic [WIDTH-1:0] strap_pin_oe,
   input wire logic [WIDTH-1:0] lcd_data_hi,
   output logic [WIDTH-1:0] boot_strap_config_byte,
   output logic [1:0] mem_size,
   output logic mem_size_valid,
   output logic config_done
);
   localparam int DECAY_AT = `DECAY_CYCLES;
   localparam int HOLD_AT = `HOLD_CYCLES;
   localparam int SAMPLE_AT = `SAMPLE_CYCLES;
   localparam logic [9:0] SAMPLE_CNT = 10'(SAMPLE_AT);
   localparam logic [9:0] PRE_CNT = 10'(`PRECHARGE_CYCLES);
   localparam logic [WIDTH-1:0] PRECHARGE = WIDTH'(`PRECHARGE_VALUE);
   localparam logic [WIDTH-1:0] ALL_IN = '0;
   localparam logic [WIDTH-1:0] ALL_OUT = '1;

   // Byte layout is fixed, and the cycle counter is ten bits wide
   if (WIDTH != `STRAP_WIDTH) begin : g_bad_width
      $error("strap width must be 8");
   end
   if (SAMPLE_AT <= DECAY_AT || SAMPLE_AT >= HOLD_AT) begin : g_bad_sample
      $error("sample point outside window");
   end
   if (HOLD_AT > 1023) begin : g_bad_count
      $error("window too long for the cycle counter");
   end

   // Four flops per pin; a change counts once stages two and three agree
   wire logic [WIDTH-1:0] level;
   for (genvar b = 0; b < WIDTH; b++) begin : g_pin_sync
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic next_s1;
      logic next_s2;
      logic next_s3;
      logic next_lvl;
      always_comb begin
         next_s1 = strap_pin_in[b];
         next_s2 = s1;
         next_s3 = s2;
         next_lvl = lvl;
         if (s2 == s3) begin
            next_lvl = s3;
         end
      end
      always_ff @(posedge core_clk) begin
         if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
         end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            lvl <= next_lvl;
         end
      end
      assign level[b] = lvl;
   end

   // Sequencer: drive, precharge, release, wait, then hand over
   boot_strap_pkg::seq_state_e state;
   boot_strap_pkg::seq_state_e next_state;
   logic [9:0] count;
   logic [9:0] next_count;
   logic sample_now;

   always_comb begin
      next_state = state;
      next_count = count + 10'h001;
      sample_now = 1'b0;
      case (state)
         boot_strap_pkg::ST_IDLE: begin
            next_count = '0;
            next_state = boot_strap_pkg::ST_PRECHARGE; // RQ3
         end
         boot_strap_pkg::ST_PRECHARGE: begin
            if (count >= PRE_CNT) begin
               next_state = boot_strap_pkg::ST_RELEASE;
            end
         end
         boot_strap_pkg::ST_RELEASE: begin
            next_count = '0;
            next_state = boot_strap_pkg::ST_WAIT;
         end
         boot_strap_pkg::ST_WAIT: begin
            // Sync latency of four cycles is small against the decay margin
            if (count == SAMPLE_CNT) begin // RQ5 RQ6 RQ12
               sample_now = 1'b1;
               next_state = boot_strap_pkg::ST_DONE;
            end
         end
         boot_strap_pkg::ST_DONE: begin
            next_count = count;
         end
         default: begin
            next_state = boot_strap_pkg::ST_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= boot_strap_pkg::ST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Pin direction and set latch
   logic [WIDTH-1:0] dir;
   logic [WIDTH-1:0] next_dir;
   logic [WIDTH-1:0] set_q;
   logic [WIDTH-1:0] next_set_q;

   always_comb begin
      next_dir = dir;
      next_set_q = set_q;
      case (state)
         boot_strap_pkg::ST_IDLE: begin
            next_dir = ALL_OUT; // RQ2
         end
         boot_strap_pkg::ST_PRECHARGE: begin
            next_set_q = set_q | PRECHARGE; // RQ10
         end
         boot_strap_pkg::ST_RELEASE: begin
            next_dir = ALL_IN; // RQ2
         end
         boot_strap_pkg::ST_DONE: begin
            next_dir = ALL_OUT; // RQ8
         end
         default: begin
            next_dir = dir;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dir <= ALL_IN; // RQ1
         set_q <= '0;
      end else begin
         dir <= next_dir;
         set_q <= next_set_q;
      end
   end

   // Captured byte and its size flag, kept until the next reset
   logic [WIDTH-1:0] cfg;
   logic [WIDTH-1:0] next_cfg;
   logic done;
   logic next_done;
   logic size_ok;
   logic next_size_ok;
   boot_strap_pkg::mem_size_e next_size_code;

   always_comb begin
      next_cfg = cfg;
      next_done = done;
      next_size_code = boot_strap_pkg::mem_size_e'(cfg[`MEM_SIZE_LSB +: 2]);
      if (sample_now) begin
         next_cfg = level; // RQ4 RQ9
         next_done = 1'b1;
         next_size_code = boot_strap_pkg::mem_size_e'(level[`MEM_SIZE_LSB +: 2]);
      end
      next_size_ok = next_done && (next_size_code != boot_strap_pkg::MEM_RSVD); // RQ11
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg <= '0;
         done <= 1'b0;
         size_ok <= 1'b0;
      end else begin
         cfg <= next_cfg; // RQ7
         done <= next_done;
         size_ok <= next_size_ok;
      end
   end

   // Display data only after capture, so straps never see it
   logic [WIDTH-1:0] pin_out_q;
   logic [WIDTH-1:0] next_pin_out;

   always_comb begin
      next_pin_out = set_q;
      if (done) begin
         next_pin_out = lcd_data_hi; // RQ8
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_out_q <= '0;
      end else begin
         pin_out_q <= next_pin_out;
      end
   end

   assign strap_pin_out = pin_out_q;
   assign strap_pin_oe = dir; // RQ1
   assign boot_strap_config_byte = cfg; // RQ7
   assign mem_size = cfg[`MEM_SIZE_LSB +: 2]; // RQ11
   assign mem_size_valid = size_ok; // RQ11
   assign config_done = done;
endmodule : boot_strap_config_reader

/* File: dv/strap_board.sv */
// Board pin model: weak pull-down where fit is one.
// Assumes all eight pins are driven and released together.
`timescale 1ns/1ps
module strap_board (
   input wire logic core_clk,
   input wire logic [7:0] strap_pin_out,
   input wire logic [7:0] strap_pin_oe,
   input wire logic [7:0] fit,
   output logic [7:0] strap_pin_in
);
   logic [7:0] lvl = 8'h00;
   int age = 0;
   // Slow decay, just inside 2 us; past 10 us every pin reads low
   always @(posedge core_clk) begin
      if (|strap_pin_oe) begin
         age <= 0;
         lvl <= strap_pin_out;
      end else begin
         age <= age + 1;
         if (age == 38) lvl <= lvl & ~fit;
         if (age == 205) lvl <= 8'h00;
      end
   end
   assign strap_pin_in = (strap_pin_oe & strap_pin_out) | (~strap_pin_oe & lvl);
endmodule : strap_board

/* File: dv/boot_strap_config_reader_sva.sv */
// Port checker for the strap reader.
// Assumes bind onto the reader.
`timescale 1ns/1ps
module strap_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] strap_pin_out,
   input wire logic [7:0] strap_pin_oe,
   input wire logic [7:0] lcd_data_hi,
   input wire logic [7:0] boot_strap_config_byte,
   input wire logic [1:0] mem_size,
   input wire logic mem_size_valid,
   input wire logic config_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_rst_in: assert property ($fell(rst) |-> !strap_pin_oe && !config_done) else $error("rst");
   chk_precharge_ones: assert property ($fell(|strap_pin_oe) |-> $past(strap_pin_out) == 8'hFF) else $error("pre");
   chk_sample_window: assert property ($fell(|strap_pin_oe) |-> ##[40:199] $rose(config_done)) else $error("win");
   chk_no_early_lcd: assert property (!config_done |-> strap_pin_out == 8'h00 || strap_pin_out == 8'hFF) else $error("lcd early");
   chk_byte_zero: assert property (!config_done |-> boot_strap_config_byte == 8'h00) else $error("early");
   chk_byte_hold: assert property (config_done |=> $stable(boot_strap_config_byte)) else $error("hold");
   chk_mem_size: assert property (config_done [*2] |-> mem_size == boot_strap_config_byte[3:2]) else $error("sz");
   chk_size_valid: assert property (mem_size_valid == (config_done && mem_size != 2'h0)) else $error("vld");
   chk_lcd_pass: assert property (config_done [*3] |-> &strap_pin_oe && strap_pin_out == $past(lcd_data_hi)) else $error("lcd");
endmodule : strap_sva
bind boot_strap_config_reader strap_sva strap_sva_i (.*);

/* File: dv/tb_boot_strap_config_reader.sv */
// Bench: six boots, each with its own strap pattern.
// Assumes strap_board on the pins and the bound checker.
`timescale 1ns/1ps
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("unexpected %0t bad", $time); end end
module tb_boot_strap_config_reader;
   logic core_clk = 0, rst = 1, mem_size_valid, config_done, done_q = 0;
   logic [7:0] strap_pin_in, strap_pin_out, strap_pin_oe, boot_strap_config_byte, fit = 0, lcd_data_hi = 0;
   logic [1:0] mem_size;
   logic [7:0] notes[$];
   int num_errors = 0, n_checks = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   boot_strap_config_reader boot_strap_config_reader_i (
      .core_clk(core_clk),
      .rst(rst),
      .strap_pin_in(strap_pin_in),
      .strap_pin_out(strap_pin_out),
      .strap_pin_oe(strap_pin_oe),
      .lcd_data_hi(lcd_data_hi),
      .boot_strap_config_byte(boot_strap_config_byte),
      .mem_size(mem_size),
      .mem_size_valid(mem_size_valid),
      .config_done(config_done)
   );
   strap_board strap_board_i (
      .core_clk(core_clk),
      .strap_pin_out(strap_pin_out),
      .strap_pin_oe(strap_pin_oe),
      .fit(fit),
      .strap_pin_in(strap_pin_in)
   );
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // Outputs settle after the rising edge, so look at the falling one
   always @(negedge core_clk) begin
      cyc <= cyc + 1;
      done_q <= config_done;
      if (config_done === 1'b1 && done_q !== 1'b1) begin
         `CMP(boot_strap_config_byte, notes[0])
         `CMP(mem_size_valid, notes[0][3:2] != 2'h0)
         void'(notes.pop_front());
      end
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      void'($urandom(32'hA0FC));
      for (int i = 0; i < 6; i++) begin
         @(negedge core_clk);
         rst = 1;
         fit = 8'($urandom);
         // Every size code once, then all-high and all-low
         if (i < 4) fit[3:2] = i[1:0];
         else fit = {8{i[0]}};
         lcd_data_hi = 8'($urandom);
         notes.push_back(~fit);
         repeat (5) @(negedge core_clk);
         rst = 0;
         for (int t = 0; t < 300 && config_done !== 1'b1; t++) @(negedge core_clk);
         `CMP(config_done, 1'b1)
         repeat (3) @(negedge core_clk);
         `CMP(mem_size, ~fit[3:2])
         `CMP(strap_pin_out, lcd_data_hi)
         $display("test %0d", i);
      end
      `CMP(notes.size(), 0)
      test_done();
   end
endmodule : tb_boot_strap_config_reader
